//--- design/crf_const_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "crf_defs.svh"
module crf_const_gen (
    // source selection
    crf_src_if.mux src
);
    import crf_pkg::*;

    // ==========================================
    // constant or register operand
    always_comb begin
        src.is_const = 1'b1;
        src.data = `CRF_K0;
        if (src.idx == `CRF_IDX_CG) begin
            unique case (src.mode)
                `CRF_AS_REG: src.data = `CRF_K0;
                `CRF_AS_IDX: src.data = `CRF_K1;
                `CRF_AS_IND: src.data = `CRF_K2;
                `CRF_AS_INC: src.data = `CRF_KM1;
            endcase
        end else if (src.idx == `CRF_IDX_SR && src.mode != `CRF_AS_REG) begin
            unique case (src.mode)
                `CRF_AS_IDX: src.data = `CRF_K0;
                `CRF_AS_IND: src.data = `CRF_K4;
                default: src.data = `CRF_K8;
            endcase
        end else begin
            src.is_const = 1'b0;
            // byte reads see the low byte only
            src.data = src.byte_op ? {8'h00, src.reg_value[7:0]} : src.reg_value;
        end
    end

endmodule : crf_const_gen
`default_nettype wire

//--- design/crf_defs.svh
`ifndef CRF_DEFS_SVH
`define CRF_DEFS_SVH

// ==========================================
// register indices
`define CRF_IDX_PC 4'h0
`define CRF_IDX_SP 4'h1
`define CRF_IDX_SR 4'h2
`define CRF_IDX_CG 4'h3

// ==========================================
// source mode encodings
`define CRF_AS_REG 2'h0
`define CRF_AS_IDX 2'h1
`define CRF_AS_IND 2'h2
`define CRF_AS_INC 2'h3

// ==========================================
// status register bit positions
`define CRF_SR_C 0
`define CRF_SR_Z 1
`define CRF_SR_N 2
`define CRF_SR_IRQ_EN 3
`define CRF_SR_HALT 4
`define CRF_SR_XOSC_OFF 5
`define CRF_SR_LOOP_OFF 6
`define CRF_SR_DCGEN_OFF 7
`define CRF_SR_V 8
`define CRF_SR_MASK 16'h01FF

// ==========================================
// constants and reset values
`define CRF_K0 16'h0000
`define CRF_K1 16'h0001
`define CRF_K2 16'h0002
`define CRF_K4 16'h0004
`define CRF_K8 16'h0008
`define CRF_KM1 16'hFFFF
`define CRF_STEP 16'h0002
`define CRF_RESET_VECTOR 16'hFFFE
`define CRF_SR_RESET 16'h0000

`endif

//--- design/crf_pkg.sv
package crf_pkg;
    typedef logic [15:0] crf_word_t;
    typedef logic [3:0] crf_idx_t;
    typedef enum logic [1:0] {
        CRF_ST_RESET = 2'b00,
        CRF_ST_VECTOR = 2'b01,
        CRF_ST_RUN = 2'b10
    } crf_state_e;
endpackage : crf_pkg

//--- design/crf_regfile.sv
`timescale 1ns/1ps
`default_nettype none
`include "crf_defs.svh"
module crf_regfile #(
    parameter int STEP_W = 2
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // source operand
    input wire crf_pkg::crf_idx_t src_idx,
    input wire logic [1:0] src_mode,
    input wire logic byte_op,
    output logic [15:0] src_data,
    output logic src_is_const,
    // second read port
    input wire crf_pkg::crf_idx_t dst_idx,
    output logic [15:0] dst_data,
    // write port
    input wire logic wr_en,
    input wire crf_pkg::crf_idx_t wr_idx,
    input wire logic [15:0] wr_data,
    input wire logic wr_is_mem,
    // flag update
    input wire logic flag_en,
    input wire logic [15:0] alu_result,
    input wire logic alu_c,
    input wire logic alu_v,
    // program counter stepping
    input wire logic pc_step,
    input wire logic [1:0] insn_words,
    // stack
    input wire logic push,
    input wire logic pop,
    input wire logic [15:0] pop_data,
    input wire logic irq_entry,
    // memory temporary
    input wire logic tmp_load,
    input wire logic [15:0] tmp_in,
    // reset vector fetch
    input wire logic [15:0] vector_data,
    input wire logic vector_valid,
    // status and addresses
    input wire logic irq_pending,
    output logic irq_take,
    output logic [15:0] fetch_addr,
    output logic [15:0] stack_addr,
    output logic [15:0] tmp_out,
    output logic [15:0] status,
    output logic ready
);
    import crf_pkg::*;

    // ==========================================
    // storage
    logic [15:1] program_counter;
    logic [15:1] stack_pointer;
    logic [15:0] status_register;
    logic [15:0] gpr [4:15];
    logic [15:0] mem_tmp;
    crf_state_e state;
    logic [15:0] sp_full;
    logic [15:0] push_addr;
    logic [15:0] next_sp;
    logic [15:0] wr_value;
    logic [15:0] rd_pc;
    logic wr_legal;
    logic neg;

    crf_src_if src ();

    assign rd_pc = {program_counter, 1'b0};
    assign sp_full = {stack_pointer, 1'b0};

    // ==========================================
    // read port feeding constant generator
    always_comb begin
        unique case (src_idx)
            `CRF_IDX_PC: src.reg_value = rd_pc;
            `CRF_IDX_SP: src.reg_value = sp_full;
            `CRF_IDX_SR: src.reg_value = status_register;
            `CRF_IDX_CG: src.reg_value = `CRF_K0;
            default: src.reg_value = gpr[src_idx];
        endcase
    end
    assign src.idx = src_idx;
    assign src.mode = src_mode;
    assign src.byte_op = byte_op;

    crf_const_gen u_cg (
        .src(src.mux)
    );

    crf_sp_unit u_sp (
        .sp(sp_full),
        .push(push),
        .pop(pop),
        .pop_to_sp(wr_en && wr_idx == `CRF_IDX_SP),
        .pop_data(pop_data),
        .push_addr(push_addr),
        .next_sp(next_sp)
    );

    // byte writes zero the upper half
    assign wr_value = byte_op ? {8'h00, wr_data[7:0]} : wr_data;
    // sr only written as a word; index 3 never written
    assign wr_legal = wr_en && wr_idx != `CRF_IDX_CG
        && !(wr_idx == `CRF_IDX_SR && byte_op);
    assign neg = byte_op ? alu_result[7] : alu_result[15];

    // ==========================================
    // reset sequencing
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= CRF_ST_RESET;
        end else begin
            unique case (state)
                CRF_ST_RESET: state <= CRF_ST_VECTOR;
                CRF_ST_VECTOR: if (vector_valid) state <= CRF_ST_RUN;
                CRF_ST_RUN: state <= CRF_ST_RUN;
                default: state <= CRF_ST_RESET;
            endcase
        end
    end

    // ==========================================
    // program counter
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            program_counter <= 15'h0000;
        end else if (state == CRF_ST_VECTOR && vector_valid) begin
            program_counter <= vector_data[15:1];
        end else if (state == CRF_ST_RUN) begin
            if (wr_legal && wr_idx == `CRF_IDX_PC) begin
                program_counter <= wr_value[15:1];
            end else if (pc_step) begin
                // step is words, so the byte count stays even
                program_counter <= program_counter + {13'h0000, insn_words};
            end
        end
    end

    // ==========================================
    // stack pointer
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            // left at zero; software must load it first
            stack_pointer <= 15'h0000;
        end else if (state == CRF_ST_RUN) begin
            if (push || pop) begin
                stack_pointer <= next_sp[15:1];
            end else if (wr_legal && wr_idx == `CRF_IDX_SP) begin
                stack_pointer <= wr_value[15:1];
            end
        end
    end

    // ==========================================
    // status register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            status_register <= `CRF_SR_RESET;
        end else if (state == CRF_ST_RUN) begin
            if (irq_entry) begin
                status_register[`CRF_SR_HALT] <= 1'b0;
                status_register[`CRF_SR_DCGEN_OFF] <= 1'b0;
                status_register[`CRF_SR_XOSC_OFF] <= 1'b0;
                status_register[`CRF_SR_IRQ_EN] <= 1'b0;
            end else if (wr_legal && wr_idx == `CRF_IDX_SR) begin
                status_register <= wr_value & `CRF_SR_MASK;
            end else if (flag_en) begin
                status_register[`CRF_SR_N] <= neg;
                status_register[`CRF_SR_Z] <= byte_op ? (alu_result[7:0] == 8'h00)
                                                      : (alu_result == 16'h0000);
                status_register[`CRF_SR_C] <= alu_c;
                status_register[`CRF_SR_V] <= alu_v;
            end
        end
    end

    // ==========================================
    // working registers, one write per cycle
    genvar gi;
    generate
        for (gi = 4; gi < 16; gi++) begin : g_gpr
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    gpr[gi] <= 16'h0000;
                end else if (wr_legal && wr_idx == 4'(gi)) begin
                    gpr[gi] <= wr_value;
                end
            end
        end
    endgenerate

    // ==========================================
    // hidden holding register for memory to memory moves
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mem_tmp <= 16'h0000;
        end else if (tmp_load) begin
            mem_tmp <= wr_is_mem && byte_op ? {8'h00, tmp_in[7:0]} : tmp_in;
        end
    end

    // ==========================================
    // registered outputs
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            src_data <= 16'h0000;
            src_is_const <= 1'b0;
            dst_data <= 16'h0000;
            fetch_addr <= 16'h0000;
            stack_addr <= 16'h0000;
            tmp_out <= 16'h0000;
            status <= 16'h0000;
            irq_take <= 1'b0;
            ready <= 1'b0;
        end else begin
            src_data <= src.data;
            src_is_const <= src.is_const;
            unique case (dst_idx)
                `CRF_IDX_PC: dst_data <= rd_pc;
                `CRF_IDX_SP: dst_data <= sp_full;
                `CRF_IDX_SR: dst_data <= status_register;
                `CRF_IDX_CG: dst_data <= `CRF_K0;
                default: dst_data <= gpr[dst_idx];
            endcase
            fetch_addr <= rd_pc;
            stack_addr <= push ? push_addr : sp_full;
            tmp_out <= mem_tmp;
            status <= status_register;
            irq_take <= irq_pending && status_register[`CRF_SR_IRQ_EN]
                        && state == CRF_ST_RUN;
            ready <= state == CRF_ST_RUN;
        end
    end

    // ==========================================
    a_pc_even: assert property (@(posedge sys_clk) disable iff (rst)
        fetch_addr[0] == 1'b0) else $error("fetch address odd");
    a_sp_even: assert property (@(posedge sys_clk) disable iff (rst)
        stack_addr[0] == 1'b0) else $error("stack address odd");
    a_push_dec: assert property (@(posedge sys_clk) disable iff (rst)
        state == CRF_ST_RUN && push && !pop |=> sp_full == $past(sp_full) - 16'h0002)
        else $error("push did not decrement");
    a_pop_inc: assert property (@(posedge sys_clk) disable iff (rst)
        state == CRF_ST_RUN && pop && !push && !(wr_en && wr_idx == `CRF_IDX_SP)
        |=> sp_full == $past(sp_full) + 16'h0002) else $error("pop did not increment");
    a_pop_sp: assert property (@(posedge sys_clk) disable iff (rst)
        state == CRF_ST_RUN && pop && !push && wr_en && wr_idx == `CRF_IDX_SP
        |=> sp_full == {$past(pop_data[15:1]), 1'b0}) else $error("pop sp wrong");
    a_pc_step: assert property (@(posedge sys_clk) disable iff (rst)
        state == CRF_ST_RUN && pc_step && !(wr_en && wr_idx == `CRF_IDX_PC)
        |=> rd_pc == $past(rd_pc) + {13'h0000, $past(insn_words), 1'b0})
        else $error("pc step wrong");
    a_irq_mask_gate: assert property (@(posedge sys_clk) disable iff (rst)
        !status_register[`CRF_SR_IRQ_EN] |=> !irq_take) else $error("irq taken while masked");
    a_byte_clear: assert property (@(posedge sys_clk) disable iff (rst)
        wr_en && byte_op && wr_idx > 4'h3 |=> gpr[$past(wr_idx)][15:8] == 8'h00)
        else $error("byte write kept upper byte");
    a_irq_clear: assert property (@(posedge sys_clk) disable iff (rst)
        state == CRF_ST_RUN && irq_entry |=> !status_register[`CRF_SR_HALT]
        && !status_register[`CRF_SR_DCGEN_OFF] && !status_register[`CRF_SR_XOSC_OFF])
        else $error("low power bits kept");
    a_cg_minus_one: assert property (@(posedge sys_clk) disable iff (rst)
        src_idx == `CRF_IDX_CG && src_mode == `CRF_AS_INC |=> src_data == `CRF_KM1)
        else $error("constant minus one wrong");
    a_sr_const_four: assert property (@(posedge sys_clk) disable iff (rst)
        src_idx == `CRF_IDX_SR && src_mode == `CRF_AS_IND |=> src_data == `CRF_K4)
        else $error("status index did not give constant");
    a_sr_byte_drop: assert property (@(posedge sys_clk) disable iff (rst)
        state == CRF_ST_RUN && wr_en && wr_idx == `CRF_IDX_SR && byte_op && !irq_entry
        && !flag_en |=> $stable(status_register)) else $error("byte write reached status");
    a_vector_load: assert property (@(posedge sys_clk) disable iff (rst)
        state == CRF_ST_VECTOR && vector_valid |=> rd_pc == {$past(vector_data[15:1]), 1'b0})
        else $error("vector not loaded");
    a_gpr_write: assert property (@(posedge sys_clk) disable iff (rst)
        wr_en && wr_idx > 4'h3 && !byte_op |=> gpr[$past(wr_idx)] == $past(wr_data))
        else $error("register write not done in one cycle");
    a_neg_flag: assert property (@(posedge sys_clk) disable iff (rst)
        state == CRF_ST_RUN && flag_en && !irq_entry && !(wr_en && wr_idx == `CRF_IDX_SR)
        |=> status_register[`CRF_SR_N] == ($past(byte_op) ? $past(alu_result[7])
        : $past(alu_result[15]))) else $error("negative flag wrong");
endmodule : crf_regfile
`default_nettype wire

//--- design/crf_sp_unit.sv
`timescale 1ns/1ps
`default_nettype none
module crf_sp_unit (
    // stack state
    input wire logic [15:0] sp,
    input wire logic push,
    input wire logic pop,
    input wire logic pop_to_sp,
    input wire logic [15:0] pop_data,
    // results
    output logic [15:0] push_addr,
    output logic [15:0] next_sp
);
    // ==========================================
    // predecrement for push, postincrement for pop
    always_comb begin
        push_addr = sp - 16'h0002;
        if (push) begin
            next_sp = push_addr;
        end else if (pop && pop_to_sp) begin
            next_sp = {pop_data[15:1], 1'b0};
        end else if (pop) begin
            next_sp = sp + 16'h0002;
        end else begin
            next_sp = sp;
        end
    end
endmodule : crf_sp_unit
`default_nettype wire

//--- design/crf_src_if.sv
`timescale 1ns/1ps
`default_nettype none
interface crf_src_if;
    logic [3:0] idx;
    logic [1:0] mode;
    logic byte_op;
    logic [15:0] reg_value;
    logic [15:0] data;
    logic is_const;
    modport core (output idx, output mode, output byte_op, output reg_value,
                  input data, input is_const);
    modport mux (input idx, input mode, input byte_op, input reg_value,
                 output data, output is_const);
endinterface : crf_src_if
`default_nettype wire

//--- dv/crf_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module crf_mem_model #(
    parameter logic [15:0] VECTOR = 16'h0000
) (
    // control
    input wire logic rst,
    input wire logic ready,
    input wire logic pop,
    input wire logic [15:0] rd_addr,
    // data
    output logic [15:0] vector_data,
    output logic vector_valid,
    output logic [15:0] pop_data
);
    logic [15:0] word;
    // ==========================================
    // memory content
    // word wide memory: address bit 0 never selects anything
    assign word = {rd_addr[15:1], 1'b0} ^ 16'h5A5A;
    // a released bus shows the inverse, so a stale value never passes
    assign pop_data = pop ? word : ~word;
    assign vector_valid = !rst && (ready !== 1'b1);
    assign vector_data = vector_valid ? VECTOR : ~VECTOR;
endmodule : crf_mem_model
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "crf_defs.svh"
module tb;
    import crf_pkg::*;
    // ==========================================
    // signals
    localparam logic [15:0] VEC = 16'hC001;
    localparam logic [15:0] KTAB [8] = '{16'h0000, 16'h0000, 16'h0004, 16'h0008,
                                       16'h0000, 16'h0001, 16'h0002, 16'hFFFF};
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    crf_idx_t src_idx, dst_idx, wr_idx;
    logic [1:0] src_mode, insn_words;
    logic [15:0] wr_data, alu_result, tmp_in, pop_data, vector_data;
    logic [15:0] src_data, dst_data, fetch_addr, stack_addr, tmp_out, status;
    logic byte_op, wr_en, wr_is_mem, flag_en, alu_c, alu_v, pc_step, push, pop;
    logic irq_entry, tmp_load, vector_valid, irq_pending, src_is_const, irq_take, ready;
    int err_total = 0;
    int checked = 0;
    always #5 sys_clk = ~sys_clk;
    crf_regfile uut (.sys_clk, .rst, .src_idx, .src_mode, .byte_op, .src_data,
        .src_is_const, .dst_idx, .dst_data, .wr_en, .wr_idx, .wr_data, .wr_is_mem,
        .flag_en, .alu_result, .alu_c, .alu_v, .pc_step, .insn_words, .push, .pop,
        .pop_data, .irq_entry, .tmp_load, .tmp_in, .vector_data, .vector_valid,
        .irq_pending, .irq_take, .fetch_addr, .stack_addr, .tmp_out, .status, .ready);
    crf_mem_model #(.VECTOR(VEC)) mem (.rst, .ready, .pop, .rd_addr(stack_addr),
        .vector_data, .vector_valid, .pop_data);
    // ==========================================
    // helpers
    task stop_test;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test
    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task tick;
        @(posedge sys_clk);
    endtask : tick
    task wr(input crf_idx_t i, input logic [15:0] d, input logic b);
        wr_idx <= i;
        wr_data <= d;
        byte_op <= b;
        wr_en <= 1'b1;
        tick();
        wr_en <= 1'b0;
        byte_op <= 1'b0;
    endtask : wr
    task rd(input crf_idx_t i, output logic [15:0] v);
        dst_idx <= i;
        tick();
        tick();
        v = dst_data;
    endtask : rd
    // ==========================================
    // scenarios
    task t_reset;
        logic [15:0] v;
        rst <= 1'b1;
        tick();
        tick();
        rst <= 1'b0;
        for (int n = 0; n < 50 && ready !== 1'b1; n++) tick();
        if (ready !== 1'b1) begin
            err_total++;
            stop_test();
        end
        rd(`CRF_IDX_PC, v);
        check("pc_vector", v, VEC & 16'hFFFE);
        check("status_reset", status, 16'h0000);
    endtask : t_reset
    task t_pc;
        logic [15:0] v, p;
        wr(`CRF_IDX_PC, 16'h1235, 1'b0);
        rd(`CRF_IDX_PC, v);
        check("pc_write", v, 16'h1234);
        p = 16'h1234;
        for (int w = 1; w < 4; w++) begin
            pc_step <= 1'b1;
            insn_words <= w[1:0];
            tick();
            pc_step <= 1'b0;
            rd(`CRF_IDX_PC, v);
            p = p + 16'(2 * w);
            check("pc_step", v, p);
            check("fetch_addr", fetch_addr, p);
        end
    endtask : t_pc
    task t_gpr;
        logic [15:0] v;
        for (int i = 4; i < 16; i++) begin
            wr(4'(i), 16'hA500 | 16'(i), 1'b0);
            tick();
        end
        for (int i = 4; i < 16; i++) begin
            rd(4'(i), v);
            check("gpr", v, 16'hA500 | 16'(i));
        end
        wr(4'h4, 16'h1234, 1'b1);
        rd(4'h4, v);
        check("gpr_byte", v, 16'h0034);
    endtask : t_gpr
    task t_stack;
        logic [15:0] v;
        wr(`CRF_IDX_SP, 16'h0401, 1'b0);
        rd(`CRF_IDX_SP, v);
        check("sp_align", v, 16'h0400);
        push <= 1'b1;
        tick();
        push <= 1'b0;
        tick();
        check("push_addr", stack_addr, 16'h03FE);
        src_idx <= `CRF_IDX_SP;
        push <= 1'b1;
        tick();
        push <= 1'b0;
        src_idx <= 4'h0;
        rd(`CRF_IDX_SP, v);
        check("push_sp", v, 16'h03FC);
        pop <= 1'b1;
        tick();
        pop <= 1'b0;
        rd(`CRF_IDX_SP, v);
        check("pop_sp_inc", v, 16'h03FE);
        pop <= 1'b1;
        wr(`CRF_IDX_SP, 16'h03FE ^ 16'h5A5A, 1'b0);
        pop <= 1'b0;
        rd(`CRF_IDX_SP, v);
        check("pop_to_sp", v, 16'h03FE ^ 16'h5A5A);
    endtask : t_stack
    task t_const;
        for (int i = 1; i < 8; i++) begin
            src_idx <= (i < 4) ? `CRF_IDX_SR : `CRF_IDX_CG;
            src_mode <= i[1:0];
            tick();
            tick();
            check("const", src_data, KTAB[i]);
            check("is_const", {15'h0, src_is_const}, 16'h0001);
        end
        src_mode <= 2'h0;
        wr(`CRF_IDX_SR, 16'h0108, 1'b0);
        src_idx <= `CRF_IDX_SR;
        tick();
        tick();
        check("sr_source", src_data, 16'h0108);
    endtask : t_const
    task t_flag(input logic [15:0] res, input logic b, input logic exp);
        flag_en <= 1'b1;
        alu_result <= res;
        alu_c <= 1'b1;
        byte_op <= b;
        tick();
        flag_en <= 1'b0;
        byte_op <= 1'b0;
        tick();
        tick();
        check("neg_flag", {15'h0, status[2]}, {15'h0, exp});
        check("carry_flag", {15'h0, status[0]}, 16'h0001);
    endtask : t_flag
    task t_status;
        wr(`CRF_IDX_SR, 16'h0008, 1'b0);
        irq_pending <= 1'b1;
        tick();
        tick();
        check("irq_on", {15'h0, irq_take}, 16'h0001);
        wr(`CRF_IDX_SR, 16'h0000, 1'b0);
        tick();
        tick();
        check("irq_off", {15'h0, irq_take}, 16'h0000);
        irq_pending <= 1'b0;
        wr(`CRF_IDX_SR, 16'h00FF, 1'b1);
        tick();
        tick();
        check("sr_byte_wr", status, 16'h0000);
        wr(`CRF_IDX_SR, 16'h00F8, 1'b0);
        irq_entry <= 1'b1;
        tick();
        irq_entry <= 1'b0;
        tick();
        tick();
        check("irq_entry", status, 16'h0040);
        t_flag(16'h0080, 1'b1, 1'b1);
        t_flag(16'h0080, 1'b0, 1'b0);
        t_flag(16'h8000, 1'b0, 1'b1);
        tmp_in <= 16'hBEEF;
        tmp_load <= 1'b1;
        tick();
        tmp_load <= 1'b0;
        tick();
        tick();
        check("tmp_hidden", tmp_out, 16'hBEEF);
        wr_is_mem <= 1'b1;
        byte_op <= 1'b1;
        tmp_load <= 1'b1;
        tick();
        wr_is_mem <= 1'b0;
        byte_op <= 1'b0;
        tmp_load <= 1'b0;
        tick();
        tick();
        check("tmp_byte", tmp_out, 16'h00EF);
    endtask : t_status
    // ==========================================
    // main sequence; reset is repeated after the last scenario on purpose
    initial begin
        {src_idx, src_mode, byte_op, dst_idx, wr_en, wr_idx, wr_data, wr_is_mem,
         flag_en, alu_result, alu_c, alu_v, pc_step, insn_words, push, pop,
         irq_entry, tmp_load, tmp_in, irq_pending} = '0;
        tick();
        t_reset();
        t_pc();
        t_gpr();
        t_stack();
        t_const();
        t_status();
        t_reset();
        stop_test();
    end
endmodule : tb
`default_nettype wire
